// >>> hdl/spi_port_pkg.sv
package spi_port_pkg;
    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_CTRL    = 3'h0;
    localparam logic [2:0] IDX_PRIO    = 3'h1;
    localparam logic [2:0] IDX_STATUS  = 3'h2;
    localparam logic [2:0] IDX_DATA    = 3'h3;
    localparam int         ADDR_W      = 5;

    // port_control fields
    localparam int CTRL_DBL  = 7;
    localparam int CTRL_EN   = 6;
    localparam int CTRL_ORD  = 5;
    localparam int CTRL_MST  = 4;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_PRE  = 0;

    // transfer_flags fields
    localparam int STAT_TC   = 7;
    localparam int STAT_WCOL = 6;

    // reset values, and the read value of the priority reserved bits
    localparam logic [7:0] CTRL_RST    = 8'h00;
    localparam logic [1:0] PRIO_RST    = 2'h0;
    localparam logic [7:0] PRIO_RSV    = 8'h00;

    // serial clock divisors, normal and double speed
    localparam logic [7:0] DIV_N0 = 8'h04;
    localparam logic [7:0] DIV_N1 = 8'h10;
    localparam logic [7:0] DIV_N2 = 8'h40;
    localparam logic [7:0] DIV_N3 = 8'h80;
    localparam logic [7:0] DIV_D0 = 8'h02;
    localparam logic [7:0] DIV_D1 = 8'h08;
    localparam logic [7:0] DIV_D2 = 8'h20;
    localparam logic [7:0] DIV_D3 = 8'h40;

    // last edge index in one byte and last bit index
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [2:0] LAST_BIT  = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_MRUN  = 2'b01,
        ST_SRUN  = 2'b10
    } fsm_e;
endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for the asynchronous serial pins
module pin_sync (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [3:0] pins_in,
    output logic      [3:0] pins_out
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
    } sync_s;

    sync_s st;
    sync_s nx;

    // first stage feeds only the second stage
    always_comb begin
        nx    = st;
        nx.s1 = pins_in;
        nx.s2 = st.s1;
    end

    // idle levels: clock low, select high (deselected)
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '{s1: 4'h8, s2: 4'h8};
        end else begin
            st <= nx;
        end
    end

    assign pins_out = st.s2;
endmodule

// >>> hdl/spi_master_slave_port.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
// Summary of operation
// [RULE1] dma request only in slave mode
// [RULE2] double speed doubles master serial clock
// [RULE3] no serial activity unless enabled
// [RULE4] bit order one sends lsb first
// [RULE5] master bit selects master or slave
// [RULE6] select low as input drops mastership
// [RULE7] lost mastership also sets complete flag
// [RULE8] mode field picks sample and setup edges
// [RULE9] serial clock idles at leading-edge opposite level
// [RULE10] normal divisors 4, 16, 64, 128
// [RULE11] double speed divisors 2, 8, 32, 64
// [RULE12] slave ignores the divider field
// [RULE13] nonzero priority enables interrupt on flag
// [RULE14] complete flag set after whole byte
// [RULE15] flag cleared by vector or status-then-data
// [RULE16] data write during transfer sets collision
// [RULE17] collision cleared by status read then data
// [RULE18] data write starts transmission
// [RULE19] data read returns last received byte
// [RULE20] software writes reserved bits as zero
// [RULE21] master shifts eight bits then stops
// [RULE22] select high releases output, drops partial byte
// [RULE23] external clock phases exceed two cycles
// [RULE24] software reads byte before next completes
// [RULE25] dma pulse coincides with buffer load
module spi_master_slave_port
    import spi_port_pkg::*;
(
    input  wire logic                           CLK,
    input  wire logic                           RESET,
    input  wire logic [spi_port_pkg::ADDR_W-1:0] ADDRESS,
    input  wire logic                           READ,
    input  wire logic                           WRITE,
    input  wire logic [31:0]                    WRITEDATA,
    input  wire logic [3:0]                     BYTEENABLE,
    output logic      [31:0]                    READDATA,
    output logic                                WAITREQUEST,
    input  wire logic                           SCK_IN,
    output logic                                SCK_OUT,
    output logic                                SCK_OE_N,
    input  wire logic                           MOSI_IN,
    output logic                                MOSI_OUT,
    output logic                                MOSI_OE_N,
    input  wire logic                           MISO_IN,
    output logic                                MISO_OUT,
    output logic                                MISO_OE_N,
    input  wire logic                           SS_N_IN,
    input  wire logic                           SS_IS_INPUT,
    input  wire logic                           IRQ_ACK,
    output logic                                IRQ,
    output logic      [1:0]                     IRQ_LEVEL,
    output logic                                DMA_REQ
);
    import spi_port_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] prio;
        logic       tc;
        logic       wcol;
        logic       arm_tc;
        logic       arm_wc;
        logic [7:0] rxbuf;
        logic [7:0] txhold;
        logic [7:0] txsh;
        logic [7:0] rxsh;
        logic       txfirst;
        fsm_e       fsm;
        logic [6:0] cnt;
        logic [3:0] edges;
        logic [2:0] bits;
        logic       sck;
        logic       sck_prev;
        logic       dout;
        logic       sck_oe_n;
        logic       mosi_oe_n;
        logic       miso_oe_n;
        logic       irq;
        logic       dma;
        logic       wreq;
        logic [7:0] rdata;
    } port_s;

    localparam port_s ST_RST = '{ctrl: CTRL_RST, prio: PRIO_RST, fsm: ST_IDLE, wreq: 1'b1,
                                 sck_oe_n: 1'b1, mosi_oe_n: 1'b1, miso_oe_n: 1'b1, default: '0};

    port_s      st;
    port_s      n;
    logic [3:0] pins_s;
    logic       sck_s;
    logic       mosi_s;
    logic       miso_s;
    logic       ss_n_s;
    logic       req;
    logic       done;
    logic       busy;
    logic       lead;
    logic       sample;
    logic       is_data;
    logic       en;
    logic       mst;
    logic       cpol;
    logic       cpha;
    logic       lsb1st;
    logic       m_done;
    logic       s_done;
    logic       mfault;

    // pins come from another party and are synchronised first
    pin_sync u_sync (
        .clk      (CLK),
        .reset    (RESET),
        .pins_in  ({SS_N_IN, MISO_IN, MOSI_IN, SCK_IN}),
        .pins_out (pins_s)
    );
    assign sck_s  = pins_s[0];
    assign mosi_s = pins_s[1];
    assign miso_s = pins_s[2];
    assign ss_n_s = pins_s[3];

    // half period minus one, in clock cycles, for the chosen divisor
    function automatic logic [6:0] half_m1(input logic dbl, input logic [1:0] pre);
        logic [7:0] div;
        div = 8'h00;
        case ({dbl, pre})
            3'b000:  div = DIV_N0;
            3'b001:  div = DIV_N1;
            3'b010:  div = DIV_N2;
            3'b011:  div = DIV_N3;
            3'b100:  div = DIV_D0;
            3'b101:  div = DIV_D1;
            3'b110:  div = DIV_D2;
            default: div = DIV_D3;
        endcase
        half_m1 = 7'((div >> 1) - 8'h01);
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
        shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic lsb);
        shift_out = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
    endfunction

    assign en     = st.ctrl[CTRL_EN];
    assign mst    = st.ctrl[CTRL_MST];
    assign cpol   = st.ctrl[CTRL_MODE+1];
    assign cpha   = st.ctrl[CTRL_MODE];
    assign lsb1st = st.ctrl[CTRL_ORD];

    // one wait cycle per access; the access takes effect when waitrequest is low
    assign req     = READ | WRITE;
    assign done    = req & ~st.wreq;
    assign is_data = (ADDRESS == {IDX_DATA, 2'b00});
    assign busy    = (st.fsm == ST_MRUN) || (st.fsm == ST_SRUN && st.bits != 3'h0);
    assign mfault  = en && mst && SS_IS_INPUT && !ss_n_s;
    assign lead    = (st.fsm == ST_MRUN) ? !st.edges[0] : (st.sck_prev == cpol);
    assign sample  = (lead != cpha);
    assign m_done  = (st.fsm == ST_MRUN) && (st.cnt == half_m1(st.ctrl[CTRL_DBL], st.ctrl[1:0]))
                     && (st.edges == LAST_EDGE);
    assign s_done  = (st.fsm == ST_SRUN) && !ss_n_s && (sck_s != st.sck_prev) && sample
                     && (st.bits == LAST_BIT);

    // next state: bus side effects, shift engine, then flag sets last so they win
    always_comb begin
        n         = st;
        n.dma     = 1'b0;
        n.wreq    = !(req && st.wreq);
        n.sck_prev = sck_s;
        // read data is captured in the wait cycle and stands at the completing edge
        if (req && st.wreq && READ) begin
            if (ADDRESS == {IDX_CTRL, 2'b00}) begin
                n.rdata = st.ctrl;
            end else if (ADDRESS == {IDX_PRIO, 2'b00}) begin
                n.rdata = PRIO_RSV | {6'h00, st.prio};
            end else if (ADDRESS == {IDX_STATUS, 2'b00}) begin
                n.rdata = {st.tc, st.wcol, 6'h00};
            end else if (is_data) begin
                n.rdata = st.rxbuf; // RULE19
            end else begin
                n.rdata = 8'h00;
            end
        end
        // status read arms the clear; any data access then completes it
        if (done && READ && ADDRESS == {IDX_STATUS, 2'b00}) begin
            n.arm_tc = st.tc;
            n.arm_wc = st.wcol;
        end
        if (done && is_data) begin
            if (st.arm_tc) n.tc = 1'b0; // RULE15
            if (st.arm_wc) n.wcol = 1'b0; // RULE17
            n.arm_tc = 1'b0;
            n.arm_wc = 1'b0;
        end
        if (IRQ_ACK) begin
            n.tc = 1'b0; // RULE15
        end
        if (done && WRITE && BYTEENABLE[0]) begin
            if (ADDRESS == {IDX_CTRL, 2'b00}) begin
                n.ctrl = WRITEDATA[7:0];
            end else if (ADDRESS == {IDX_PRIO, 2'b00}) begin
                n.prio = WRITEDATA[1:0];
            end
        end
        // shift engine
        case (st.fsm)
            ST_IDLE: begin
                n.sck = cpol; // RULE9
                n.cnt = 7'h00;
                n.edges = 4'h0;
                n.bits = 3'h0;
                if (en && !mst && !ss_n_s) begin
                    n.fsm = ST_SRUN;
                end
            end
            ST_MRUN: begin
                // divider only matters here, never in slave mode
                if (st.cnt == half_m1(st.ctrl[CTRL_DBL], st.ctrl[1:0])) begin // RULE2 RULE10 RULE11
                    n.cnt = 7'h00;
                    n.sck = !st.sck;
                    n.edges = 4'(st.edges + 4'h1);
                    if (sample) begin // RULE8
                        n.rxsh = shift_in(st.rxsh, miso_s, lsb1st);
                    end else if (st.txfirst) begin
                        n.txfirst = 1'b0;
                    end else begin
                        n.txsh = shift_out(st.txsh, lsb1st); // RULE4
                    end
                    if (st.edges == LAST_EDGE) begin
                        n.fsm = ST_IDLE; // RULE21
                        n.rxbuf = n.rxsh;
                    end
                end else begin
                    n.cnt = 7'(st.cnt + 7'h01);
                end
            end
            ST_SRUN: begin
                // timing comes only from the external clock; relies on phases over two cycles
                if (ss_n_s) begin
                    n.fsm = ST_IDLE; // RULE22
                    n.bits = 3'h0;
                    n.txsh = st.txhold;
                    n.txfirst = cpha;
                end else if (sck_s != st.sck_prev) begin // RULE12 RULE23
                    if (sample) begin // RULE8
                        n.rxsh = shift_in(st.rxsh, mosi_s, lsb1st);
                        n.bits = 3'(st.bits + 3'h1);
                        if (st.bits == LAST_BIT) begin
                            // single receive buffer: an unread byte is overwritten
                            n.rxbuf = n.rxsh; // RULE24
                            n.dma = 1'b1; // RULE1 RULE25
                            n.txsh = st.txhold;
                            n.txfirst = 1'b1;
                        end
                    end else if (st.txfirst) begin
                        n.txfirst = 1'b0;
                    end else begin
                        n.txsh = shift_out(st.txsh, lsb1st); // RULE4
                    end
                end
            end
            default: n.fsm = ST_IDLE;
        endcase
        // data write: start a byte, or flag a collision while one runs
        if (done && WRITE && BYTEENABLE[0] && is_data) begin
            if (busy) begin
                n.wcol = 1'b1; // RULE16
            end else begin
                n.txhold = WRITEDATA[7:0];
                if (st.fsm != ST_SRUN || st.bits == 3'h0) begin
                    n.txsh = WRITEDATA[7:0];
                    n.txfirst = cpha;
                end
                if (en && mst) begin
                    n.fsm = ST_MRUN; // RULE18 RULE5
                    n.cnt = 7'h00;
                    n.edges = 4'h0;
                    n.sck = cpol;
                end
            end
        end
        if (m_done || s_done) begin
            n.tc = 1'b1; // RULE14
        end
        // another master pulls select low: step down and tell software
        if (mfault) begin
            n.ctrl[CTRL_MST] = 1'b0; // RULE6
            n.tc = 1'b1; // RULE7
            n.fsm = ST_IDLE;
        end
        if (!n.ctrl[CTRL_EN]) begin
            n.fsm = ST_IDLE; // RULE3
            n.bits = 3'h0;
        end
        // pin drivers follow mode; output enables are active low
        n.sck_oe_n  = !(n.ctrl[CTRL_EN] && n.ctrl[CTRL_MST]); // RULE5
        n.mosi_oe_n = n.sck_oe_n;
        n.miso_oe_n = !(n.fsm == ST_SRUN && !ss_n_s); // RULE22
        n.dout      = n.ctrl[CTRL_ORD] ? n.txsh[0] : n.txsh[7];
        n.irq       = n.tc && (n.prio != 2'h0); // RULE13
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            st <= ST_RST;
        end else begin
            st <= n;
        end
    end

    assign READDATA    = {24'h00_0000, st.rdata};
    assign WAITREQUEST = st.wreq;
    assign SCK_OUT     = st.sck;
    assign SCK_OE_N    = st.sck_oe_n;
    assign MOSI_OUT    = st.dout;
    assign MOSI_OE_N   = st.mosi_oe_n;
    assign MISO_OUT    = st.dout;
    assign MISO_OE_N   = st.miso_oe_n;
    assign IRQ         = st.irq;
    assign IRQ_LEVEL   = st.prio;
    assign DMA_REQ     = st.dma;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_dma_slave_only;
        DMA_REQ |-> $past(!st.ctrl[CTRL_MST]) && st.fsm != ST_MRUN;
    endproperty
    a_dma_slave_only: assert property (p_dma_slave_only) else $error("dma request in master mode"); // RULE1

    property p_dma_with_load;
        s_done && !mfault && en |=> DMA_REQ && st.rxbuf == $past(n.rxsh);
    endproperty
    a_dma_with_load: assert property (p_dma_with_load) else $error("dma pulse not with buffer load"); // RULE25

    property p_disabled_quiet;
        !en ##1 !en |-> SCK_OE_N && MOSI_OE_N && MISO_OE_N && st.fsm == ST_IDLE;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("pins driven while disabled"); // RULE3

    property p_sck_rest;
        st.fsm == ST_IDLE && $past(st.fsm) == ST_IDLE && $stable(cpol) |-> SCK_OUT == cpol;
    endproperty
    a_sck_rest: assert property (p_sck_rest) else $error("serial clock not at idle level"); // RULE9

    property p_half_period;
        st.fsm == ST_MRUN && st.cnt == half_m1(st.ctrl[CTRL_DBL], st.ctrl[1:0]) && !mfault
        && !(done && WRITE)
        |=> SCK_OUT != $past(SCK_OUT) && st.cnt == 7'h00;
    endproperty
    a_half_period: assert property (p_half_period) else $error("serial clock toggled off count"); // RULE10

    property p_mode_fault;
        mfault |=> !st.ctrl[CTRL_MST] && st.tc && st.fsm == ST_IDLE;
    endproperty
    a_mode_fault: assert property (p_mode_fault) else $error("select fault not handled"); // RULE6

    property p_collision;
        done && WRITE && BYTEENABLE[0] && is_data && busy |=> st.wcol;
    endproperty
    a_collision: assert property (p_collision) else $error("collision flag not set"); // RULE16

    property p_master_done;
        m_done && !mfault && en |=> st.tc && st.fsm == ST_IDLE ##1 st.fsm == ST_IDLE;
    endproperty
    a_master_done: assert property (p_master_done) else $error("master byte end wrong"); // RULE21

    property p_ss_release;
        st.fsm == ST_SRUN && ss_n_s |=> MISO_OE_N && st.bits == 3'h0;
    endproperty
    a_ss_release: assert property (p_ss_release) else $error("select high did not release"); // RULE22

    property p_irq_level;
        IRQ |-> st.tc && IRQ_LEVEL != 2'h0;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt without flag or level"); // RULE13
endmodule

// >>> test/spi_slave_model.sv
`timescale 1ns/1ps
// far-side serial slave; sees the resolved wire levels
module spi_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [1:0] mode,
    input  wire logic       lsb_first,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic      [7:0] rx_byte
);
    logic last_sck = 1'b0;
    logic out_bit  = 1'b0;
    int   bits     = 0;

    function automatic int pos(input int n);
        return lsb_first ? n : 7 - n;
    endfunction

    // released line shows the inverse of the last bit, never a stale copy
    assign miso = sel_n ? ~out_bit : out_bit;

    // select starts a fresh byte with its first bit ready
    always @(negedge sel_n) begin
        bits    = 0;
        rx_byte = 8'h00;
        out_bit = tx_byte[pos(0)];
    end

    // leading edge leaves the idle level; sampling edge flips with phase
    always @(sck) begin
        if (!sel_n && sck !== last_sck) begin
            if ((sck != mode[1]) ^ mode[0]) begin
                if (bits < 8) rx_byte[pos(bits)] = mosi;
                bits++;
            end else if (bits < 8) begin
                out_bit = tx_byte[pos(bits)];
            end
        end
        last_sck = sck;
    end
endmodule

// >>> test/spi_master_slave_port_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module spi_master_slave_port_tb;
    import spi_port_pkg::*;
    logic        CLK = 1'b0, RESET = 1'b1, READ = 1'b0, WRITE = 1'b0;
    logic [4:0]  ADDRESS = 5'h00;
    logic [31:0] WRITEDATA = 32'h0000_0000;
    logic [31:0] READDATA;
    logic        WAITREQUEST, SCK_OUT, SCK_OE_N, MOSI_OUT, MOSI_OE_N, MISO_OUT, MISO_OE_N;
    logic        IRQ, DMA_REQ, SS_IS_INPUT = 1'b0, IRQ_ACK = 1'b0;
    logic [1:0]  IRQ_LEVEL, m_mode = 2'h0;
    logic        ext_sck = 1'b0, ext_mosi = 1'b0, ext_ss_n = 1'b1, slv_sel_n = 1'b1, m_ord = 1'b0;
    logic [7:0]  s_tx = 8'h00, part_rx, r, st, d, mo, mi;
    logic        sck_w, mosi_w, miso_w, part_miso, sck_prev = 1'b0;
    int          bad_count = 0, total_checks = 0, edge_cnt = 0, dma_cnt = 0, cyc = 0, t1, t2, div, n;
    int          dn[4] = '{4, 16, 64, 128};
    int          dd[4] = '{2, 8, 32, 64};
    logic [7:0]  exp_q[$];

    always #20 CLK = ~CLK;

    // wire levels from the port's enables
    assign sck_w  = !SCK_OE_N ? SCK_OUT : ext_sck;
    assign mosi_w = !MOSI_OE_N ? MOSI_OUT : ext_mosi;
    assign miso_w = !MISO_OE_N ? MISO_OUT : part_miso;

    spi_master_slave_port dut (.CLK(CLK), .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .BYTEENABLE(4'hf), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
        .SCK_IN(sck_w), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .MOSI_IN(mosi_w), .MOSI_OUT(MOSI_OUT),
        .MOSI_OE_N(MOSI_OE_N), .MISO_IN(miso_w), .MISO_OUT(MISO_OUT), .MISO_OE_N(MISO_OE_N),
        .SS_N_IN(ext_ss_n), .SS_IS_INPUT(SS_IS_INPUT), .IRQ_ACK(IRQ_ACK), .IRQ(IRQ),
        .IRQ_LEVEL(IRQ_LEVEL), .DMA_REQ(DMA_REQ));

    spi_slave_model slave (.sck(sck_w), .mosi(mosi_w), .sel_n(slv_sel_n), .mode(m_mode),
        .lsb_first(m_ord), .tx_byte(s_tx), .miso(part_miso), .rx_byte(part_rx));

    // serial clock edges and dma pulses, sampled on the bus clock
    always @(posedge CLK) begin
        cyc++;
        if (SCK_OUT !== sck_prev) begin
            edge_cnt++;
            if (edge_cnt == 1) t1 = cyc;
            if (edge_cnt == 2) t2 = cyc;
        end
        sck_prev = SCK_OUT;
        if (DMA_REQ === 1'b1) dma_cnt++;
    end

    // one access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input int idx, input logic [7:0] wd, output logic [7:0] rd_v);
        int k;
        k = 0;
        ADDRESS   <= 5'(idx * 4);
        WRITEDATA <= 32'(wd);
        WRITE     <= wr;
        READ      <= !wr;
        do @(posedge CLK); while (WAITREQUEST !== 1'b0 && ++k < 50);
        if (k >= 50) bad_count++;
        rd_v = READDATA[7:0];
        WRITE <= 1'b0;
        READ  <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic wr(input int idx, input logic [7:0] wd);
        logic [7:0] dummy;
        bus(1'b1, idx, wd, dummy);
    endtask

    task automatic rd(input int idx, output logic [7:0] v);
        bus(1'b0, idx, 8'h00, v);
    endtask

    // polling the flags also arms their clear for the next data access
    task automatic wait_tc(output logic [7:0] s);
        int k;
        k = 0;
        do rd(IDX_STATUS, s); while (s[STAT_TC] !== 1'b1 && ++k < 2000);
        if (k >= 2000) bad_count++;
    endtask

    // external master in mode 0, msb first; phases of six cycles
    task automatic xfer(input logic [7:0] o, output logic [7:0] i, input int nb);
        ext_ss_n <= 1'b0;
        repeat (6) @(posedge CLK);
        for (int b = 0; b < nb; b++) begin
            ext_mosi <= o[7-b];
            repeat (6) @(posedge CLK);
            i[7-b] = miso_w;
            ext_sck <= 1'b1;
            repeat (6) @(posedge CLK);
            ext_sck <= 1'b0;
        end
        repeat (6) @(posedge CLK);
        ext_ss_n <= 1'b1;
        if (nb == 8) exp_q.push_back(o);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // a hang is cut short well past the longest expected run
    initial begin
        repeat (40000) @(posedge CLK);
        bad_count++;
        finish_test();
    end

    initial begin
        void'($urandom(39745));
        repeat (6) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        // reset values, then write and read back of control and priority, the read-only status and the unmapped address
        for (int a = 0; a < 5; a++) begin
            if (a != 3) begin
                rd(a, r);
                `CHK(r, 8'h00)
                // reserved bits are written as zero
                wr(a, (a == 1) ? 8'h03 : (a == 2) ? 8'hc0 : 8'hff);
                rd(a, r);
                `CHK(r, (a == 0) ? 8'hff : (a == 1) ? 8'h03 : 8'h00)
            end
        end
        wr(IDX_PRIO, 8'h00);
        // disabled master must stay quiet; let the idle level settle first
        wr(IDX_CTRL, 8'h10);
        repeat (2) @(posedge CLK);
        edge_cnt = 0;
        wr(IDX_DATA, 8'ha5);
        repeat (40) @(posedge CLK);
        `CHK(edge_cnt, 0)
        `CHK(SCK_OE_N, 1'b1)
        // every rate, mode, order and priority as master
        for (int i = 0; i < 8; i++) begin
            div    = i[2] ? dd[i[1:0]] : dn[i[1:0]];
            m_mode = i[1:0];
            m_ord  = i[2] ^ i[0];
            s_tx   = 8'($urandom);
            d      = 8'($urandom);
            slv_sel_n <= 1'b1;
            wr(IDX_PRIO, {6'h00, m_mode});
            wr(IDX_CTRL, {i[2], 1'b1, m_ord, 1'b1, m_mode, m_mode[1:0]});
            // select only after the idle level has moved, so no false edge
            @(posedge CLK);
            slv_sel_n <= 1'b0;
            repeat (3) @(posedge CLK);
            `CHK(SCK_OUT, m_mode[1])
            `CHK(SCK_OE_N, 1'b0)
            edge_cnt = 0;
            wr(IDX_DATA, d);
            wait_tc(st);
            `CHK(edge_cnt, 16)
            `CHK(2 * (t2 - t1), div)
            `CHK(st, 8'h80)
            `CHK(IRQ, m_mode != 2'h0)
            `CHK(IRQ_LEVEL, m_mode)
            `CHK(part_rx, d)
            rd(IDX_DATA, r);
            // synchronised input lags two cycles, so only half periods of four or more receive
            if (div >= 8) `CHK(r, s_tx)
            rd(IDX_STATUS, r);
            `CHK(r, 8'h00)
        end
        `CHK(dma_cnt, 0)
        // second write in mid-transfer is dropped and flagged
        slv_sel_n <= 1'b1;
        m_mode = 2'h0;
        m_ord  = 1'b0;
        wr(IDX_CTRL, 8'h53);
        @(posedge CLK);
        slv_sel_n <= 1'b0;
        d = 8'($urandom);
        wr(IDX_DATA, d);
        wr(IDX_DATA, ~d);
        wait_tc(st);
        `CHK(st, 8'hc0)
        `CHK(part_rx, d)
        rd(IDX_DATA, r);
        rd(IDX_STATUS, r);
        `CHK(r, 8'h00)
        // vector execution clears the flag
        wr(IDX_DATA, d);
        n = 0;
        while (IRQ !== 1'b1 && n < 3000) begin
            @(posedge CLK);
            n++;
        end
        `CHK(IRQ, 1'b1)
        IRQ_ACK <= 1'b1;
        @(posedge CLK);
        IRQ_ACK <= 1'b0;
        rd(IDX_STATUS, r);
        `CHK(r, 8'h00)
        // another master pulls select low
        SS_IS_INPUT <= 1'b1;
        ext_ss_n    <= 1'b0;
        repeat (6) @(posedge CLK);
        ext_ss_n <= 1'b1;
        repeat (4) @(posedge CLK);
        rd(IDX_CTRL, r);
        `CHK(r, 8'h43)
        rd(IDX_STATUS, r);
        `CHK(r, 8'h80)
        rd(IDX_DATA, r);
        // slave with the slowest divider left set; it must not matter
        s_tx = 8'($urandom);
        wr(IDX_DATA, s_tx);
        dma_cnt = 0;
        mo = 8'($urandom);
        xfer(mo, mi, 8);
        `CHK(dma_cnt, 1)
        `CHK(mi, s_tx)
        `CHK(SCK_OE_N, 1'b1)
        rd(IDX_STATUS, r);
        `CHK(r, 8'h80)
        rd(IDX_DATA, r);
        `CHK(r, exp_q.pop_front())
        // partial byte is dropped when select rises
        xfer(8'($urandom), mi, 3);
        repeat (4) @(posedge CLK);
        `CHK(MISO_OE_N, 1'b1)
        xfer(8'($urandom), mi, 8);
        rd(IDX_STATUS, r);
        rd(IDX_DATA, r);
        `CHK(r, exp_q.pop_front())
        finish_test();
    end
endmodule
